// ---- sarc_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none

// Operation
// [R01] Control bits 7..4 choose one of sixteen analog inputs.
// [R02] Writing one to control bit 0 starts a conversion.
// [R03] Each conversion starts with the approximation register at 200H.
// [R04] One result bit is resolved per step, ten steps in all.
// [R05] Only the selected channel is converted in one conversion.
// [R06] End of conversion sets the flag in control bit 3.
// [R07] Result is loaded, then the block idles until the next start.
// [R08] A new conversion overwrites the stored result.
// [R09] Control bits 2..1 select the conversion clock speed.
// [R10] Control register is read/write at address D2H.
// [R11] The first decision compares against the half-supply tap.
// [R12] A rewritten channel field applies to the next conversion.
// [R13] Four clocks per bit plus ten set-up clocks, fifty in total.
// [R14] Result is split into eight upper and two lower bits.
// [R15] Starting a conversion clears the end-of-conversion flag.
module sarc_ctrl
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Analog front end
    input  wire logic        comp_high,
    output var  logic [3:0]  analog_input_channels,
    output var  logic [9:0]  dac_trial,
    output var  logic        conv_active,
    // Interrupt
    output var  logic        irq
);

    sarc_pkg::sarc_state_t state;
    logic [7:0] converter_control;
    logic [9:0] sar;
    logic [9:0] conversion_result;
    logic [3:0] bit_idx;
    logic [1:0] sub_clk;
    logic [3:0] setup_cnt;
    logic [3:0] conv_channel;
    logic [4:0] div_count;
    logic       conv_tick;
    logic       irq_status;
    logic       irq_mask;
    logic       done_evt;
    logic       wr_en;
    logic       rd_en;
    logic       start_req;

    // Address decode used only for pslverr; read and write paths compare paddr directly
    function automatic logic addr_known(input logic [9:0] a);
        addr_known = (a == sarc_pkg::CTRL_OFS) || (a == sarc_pkg::UPPER_OFS)
            || (a == sarc_pkg::LOWER_OFS) || (a == sarc_pkg::IRQ_ST_OFS)
            || (a == sarc_pkg::IRQ_MSK_OFS);
    endfunction

    // One wait cycle; a write lands only on the edge that completes it
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && penable && !pwrite && !pready;
    assign start_req = wr_en && (paddr == sarc_pkg::CTRL_OFS)
        && pwdata[sarc_pkg::START_BIT]; // [R02]

    // Speed code to divisor
    always_comb
    begin
        case (converter_control[sarc_pkg::SPD_MSB:sarc_pkg::SPD_LSB]) // [R09]
            2'b00:   div_count = sarc_pkg::DIV_SPD0;
            2'b01:   div_count = sarc_pkg::DIV_SPD1;
            2'b10:   div_count = sarc_pkg::DIV_SPD2;
            default: div_count = sarc_pkg::DIV_SPD3;
        endcase
    end

    sarc_tick u_tick
    (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .run       (state != sarc_pkg::SARC_IDLE),
        .div_count (div_count),
        .tick      (conv_tick)
    );

    // APB handshake: pready pulses one cycle into the access phase
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !addr_known(paddr);
            if (rd_en)
            begin
                if (paddr == sarc_pkg::CTRL_OFS) // [R10]
                    prdata <= {24'h000000, converter_control};
                else if (paddr == sarc_pkg::UPPER_OFS)
                    prdata <= {24'h000000, conversion_result[9:2]}; // [R14]
                else if (paddr == sarc_pkg::LOWER_OFS)
                    prdata <= {30'h00000000, conversion_result[1:0]}; // [R14]
                else if (paddr == sarc_pkg::IRQ_ST_OFS)
                    prdata <= {31'h00000000, irq_status};
                else if (paddr == sarc_pkg::IRQ_MSK_OFS)
                    prdata <= {31'h00000000, irq_mask};
                else
                    prdata <= 32'h0000_0000;
            end
        end
    end

    // Control register; start bit reads back high while busy
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            converter_control <= sarc_pkg::CTRL_RST;
        else
        begin
            if (wr_en && paddr == sarc_pkg::CTRL_OFS) // [R10]
            begin
                converter_control[sarc_pkg::CH_MSB:sarc_pkg::CH_LSB]
                    <= pwdata[7:4]; // [R01] [R12]
                converter_control[sarc_pkg::SPD_MSB:sarc_pkg::SPD_LSB]
                    <= pwdata[2:1]; // [R09]
            end
            // A start accepted in idle beats a same-cycle completion
            if (start_req && state == sarc_pkg::SARC_IDLE)
            begin
                converter_control[sarc_pkg::EOC_BIT]   <= 1'b0; // [R15]
                converter_control[sarc_pkg::START_BIT] <= 1'b1; // [R02]
            end
            else if (done_evt)
            begin
                converter_control[sarc_pkg::EOC_BIT]   <= 1'b1; // [R06]
                converter_control[sarc_pkg::START_BIT] <= 1'b0;
            end
        end
    end

    // Conversion sequencer; a start while busy is ignored
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state        <= sarc_pkg::SARC_IDLE;
            sar          <= sarc_pkg::MID_SCALE;
            bit_idx      <= 4'h9;
            sub_clk      <= 2'h0;
            setup_cnt    <= 4'h0;
            conv_channel <= 4'h0;
            done_evt     <= 1'b0;
        end
        else
        begin
            done_evt <= 1'b0;
            case (state)
                sarc_pkg::SARC_IDLE:
                begin
                    if (start_req)
                    begin
                        // Channel latched once: one input per conversion
                        conv_channel <= pwdata[7:4]; // [R05] [R12]
                        sar          <= sarc_pkg::MID_SCALE; // [R03] [R11]
                        bit_idx      <= 4'(sarc_pkg::RES_BITS - 1);
                        sub_clk      <= 2'h0;
                        setup_cnt    <= 4'h0;
                        state        <= sarc_pkg::SARC_SETUP;
                    end
                end
                sarc_pkg::SARC_SETUP:
                begin
                    if (conv_tick)
                    begin
                        if (setup_cnt == 4'(sarc_pkg::SETUP_CLKS - 1)) // [R13]
                            state <= sarc_pkg::SARC_STEP;
                        else
                            setup_cnt <= setup_cnt + 4'h1;
                    end
                end
                sarc_pkg::SARC_STEP:
                begin
                    if (conv_tick)
                    begin
                        sub_clk <= sub_clk + 2'h1;
                        // Decide on the last of four clocks per bit
                        if (sub_clk == 2'(sarc_pkg::CLKS_PER_BIT - 1)) // [R13]
                        begin
                            if (!comp_high)
                                sar[bit_idx] <= 1'b0; // [R04]
                            if (bit_idx == 4'h0)
                            begin
                                state    <= sarc_pkg::SARC_IDLE; // [R07]
                                done_evt <= 1'b1;
                            end
                            else
                            begin
                                sar[bit_idx - 4'h1] <= 1'b1; // [R04]
                                bit_idx <= bit_idx - 4'h1;
                            end
                        end
                    end
                end
                default: state <= sarc_pkg::SARC_IDLE;
            endcase
        end
    end

    // Result register; a later conversion overwrites it
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            conversion_result <= sarc_pkg::RESULT_RST;
        else if (state == sarc_pkg::SARC_STEP && conv_tick
                 && sub_clk == 2'(sarc_pkg::CLKS_PER_BIT - 1)
                 && bit_idx == 4'h0)
            conversion_result <= {sar[9:1], comp_high}; // [R07] [R08]
    end

    // Sticky completion status, write one to clear, set wins
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_status <= 1'b0;
            irq_mask   <= 1'b0;
            irq        <= 1'b0;
        end
        else
        begin
            if (done_evt)
                irq_status <= 1'b1;
            else if (wr_en && paddr == sarc_pkg::IRQ_ST_OFS && pwdata[0])
                irq_status <= 1'b0;
            if (wr_en && paddr == sarc_pkg::IRQ_MSK_OFS)
                irq_mask <= pwdata[0];
            irq <= irq_status && irq_mask;
        end
    end

    // Front-end drive, all registered
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            analog_input_channels <= 4'h0;
            dac_trial             <= sarc_pkg::MID_SCALE;
            conv_active           <= 1'b0;
        end
        else
        begin
            analog_input_channels <= conv_channel; // [R01]
            dac_trial             <= sar; // [R11]
            conv_active           <= state != sarc_pkg::SARC_IDLE;
        end
    end

    // Conversion length in conversion ticks
    logic [6:0] tick_cnt;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            tick_cnt <= 7'h00;
        else if (state == sarc_pkg::SARC_IDLE)
            tick_cnt <= 7'h00;
        else if (conv_tick)
            tick_cnt <= tick_cnt + 7'h01;
    end

    sequence start_seen_s;
        state == sarc_pkg::SARC_IDLE && start_req;
    endsequence

    property start_mid_p;
        @(posedge sys_clk) disable iff (!reset_n)
        start_seen_s |=> sar == 10'h200;
    endproperty
    start_mid_a: assert property (start_mid_p) // [R03]
        else $error("conversion did not start at mid scale");

    start_clears_eoc_a: assert property (@(posedge sys_clk) // [R15]
        disable iff (!reset_n) start_seen_s |=> !converter_control[3])
        else $error("start did not clear end flag");

    eoc_set_a: assert property (@(posedge sys_clk) // [R06]
        disable iff (!reset_n) done_evt && !start_req |=> converter_control[3])
        else $error("end flag not set on completion");

    total_clks_a: assert property (@(posedge sys_clk) // [R13]
        disable iff (!reset_n)
        done_evt |-> tick_cnt == 7'(sarc_pkg::TOTAL_CLKS))
        else $error("conversion length not fifty clocks");

    idle_after_a: assert property (@(posedge sys_clk) // [R07]
        disable iff (!reset_n) done_evt |-> state == sarc_pkg::SARC_IDLE)
        else $error("not idle after conversion");

    chan_hold_a: assert property (@(posedge sys_clk) // [R05]
        disable iff (!reset_n)
        state == sarc_pkg::SARC_STEP && $past(state) == sarc_pkg::SARC_STEP
        |-> $stable(conv_channel))
        else $error("channel changed during conversion");

    irq_level_a: assert property (@(posedge sys_clk) // [R06]
        disable iff (!reset_n) irq_status && irq_mask |=> irq)
        else $error("interrupt not raised");

    result_split_a: assert property (@(posedge sys_clk) // [R14]
        disable iff (!reset_n)
        rd_en && paddr == sarc_pkg::LOWER_OFS |=> prdata[31:2] == 30'h0)
        else $error("lower result has stray bits");

endmodule

`default_nettype wire

// ---- sarc_pkg.sv ----
package sarc_pkg;

    // Register indices; each register is one word at four times its index
    localparam logic [7:0] CTRL_IDX    = 8'hD2;
    localparam logic [7:0] UPPER_IDX   = 8'hD3;
    localparam logic [7:0] LOWER_IDX   = 8'hD4;
    localparam logic [7:0] IRQ_ST_IDX  = 8'hD5;
    localparam logic [7:0] IRQ_MSK_IDX = 8'hD6;

    // Register byte addresses on the APB slave
    localparam logic [9:0] CTRL_OFS    = {CTRL_IDX, 2'h0};
    localparam logic [9:0] UPPER_OFS   = {UPPER_IDX, 2'h0};
    localparam logic [9:0] LOWER_OFS   = {LOWER_IDX, 2'h0};
    localparam logic [9:0] IRQ_ST_OFS  = {IRQ_ST_IDX, 2'h0};
    localparam logic [9:0] IRQ_MSK_OFS = {IRQ_MSK_IDX, 2'h0};

    // Control register fields
    localparam int CH_MSB    = 7;
    localparam int CH_LSB    = 4;
    localparam int EOC_BIT   = 3;
    localparam int SPD_MSB   = 2;
    localparam int SPD_LSB   = 1;
    localparam int START_BIT = 0;

    // Reset values
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [9:0] RESULT_RST = 10'h000;
    localparam logic [9:0] MID_SCALE  = 10'h200;

    // Conversion timing in conversion clocks
    localparam int CLKS_PER_BIT = 4;
    localparam int SETUP_CLKS   = 10;
    localparam int RES_BITS     = 10;
    localparam int TOTAL_CLKS   = CLKS_PER_BIT * RES_BITS + SETUP_CLKS;

    // Conversion clock divisor for each speed code, in sys_clk cycles
    localparam logic [4:0] DIV_SPD0 = 5'h10;
    localparam logic [4:0] DIV_SPD1 = 5'h08;
    localparam logic [4:0] DIV_SPD2 = 5'h04;
    localparam logic [4:0] DIV_SPD3 = 5'h01;

    typedef enum logic [2:0] {
        SARC_IDLE  = 3'b001,
        SARC_SETUP = 3'b010,
        SARC_STEP  = 3'b100
    } sarc_state_t;

    // Request toward the analog front end
    typedef struct packed {
        logic [3:0] channel;
        logic [9:0] trial;
        logic       sample;
    } sarc_analog_t;

    // APB request bundle
    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [9:0] paddr;
        logic [31:0] pwdata;
    } sarc_apb_req_t;

endpackage

// ---- sarc_tick.sv ----
`timescale 1ns/1ps
`default_nettype none

// Conversion clock divider; one pulse every div_count sys_clk cycles
module sarc_tick
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // Control
    input  wire logic       run,
    input  wire logic [4:0] div_count,
    // Output
    output var  logic       tick
);

    logic [4:0] count;

    // Restart on every new conversion so the first step has a full period
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count <= 5'h00;
            tick  <= 1'b0;
        end
        else if (!run)
        begin
            count <= 5'h00;
            tick  <= 1'b0;
        end
        else if (count + 5'h01 >= div_count)
        begin
            count <= 5'h00;
            tick  <= 1'b1;
        end
        else
        begin
            count <= count + 5'h01;
            tick  <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ---- sarc_afe_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behavioural comparator, reference ladder and input mux
module sarc_afe_model
(
    // Clock
    input  wire logic       sys_clk,
    // Converter side
    input  wire logic [3:0] analog_input_channels,
    input  wire logic [9:0] dac_trial,
    input  wire logic       conv_active,
    output var  logic       comp_high
);
    logic       idle_toggle = 1'h0;
    logic [9:0] level;

    // Input level per channel; never mid-scale so a stale trial shows up
    assign level = {analog_input_channels, 6'h00} ^ 10'h15B;

    // Outside a conversion the output wanders, so idle reads are not trusted
    always_ff @(posedge sys_clk)
        idle_toggle <= ~idle_toggle;

    // Keep the trial bit while the input is at or above the ladder tap
    assign comp_high = conv_active ? (level >= dac_trial) : idle_toggle;

endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                    sys_clk     = 1'h0;
    logic                    reset_n     = 1'h0;
    sarc_pkg::sarc_apb_req_t req         = '0;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    comp_high;
    logic [3:0]              chan;
    logic [9:0]              dac_trial;
    logic                    conv_active;
    logic                    irq;
    logic [31:0]             rd;
    logic                    err;
    int                      mismatches  = 0;
    int                      checks      = 0;
    int                      busy        = 0;

    // 100 MHz system clock
    always #5 sys_clk = ~sys_clk;

    // Cycles spent converting, summed over the whole run
    always @(posedge sys_clk)
        if (conv_active === 1'h1)
            busy <= busy + 1;

    sarc_ctrl u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .psel(req.psel), .penable(req.penable), .pwrite(req.pwrite),
        .paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .comp_high(comp_high),
        .analog_input_channels(chan), .dac_trial(dac_trial),
        .conv_active(conv_active), .irq(irq));

    sarc_afe_model u_afe (.sys_clk(sys_clk), .analog_input_channels(chan),
        .dac_trial(dac_trial), .conv_active(conv_active),
        .comp_high(comp_high));

    // Verdict and end of run
    task automatic stop_test();
        $display("Counts: %0d mismatches, %0d checks", mismatches, checks);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic give_up(input string what);
        mismatches++;
        $display("CHECK FAILED at %0t: timeout in %s", $time, what);
        stop_test();
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
                            input string what);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp,
                            input string what);
        chk_word({31'h0, got}, {31'h0, exp}, what);
    endtask

    // One APB transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [9:0] addr,
                       input logic [31:0] wdata);
        int n;
        n = 0;
        @(posedge sys_clk);
        req.psel    <= 1'h1;
        req.penable <= 1'h0;
        req.pwrite  <= wr;
        req.paddr   <= addr;
        req.pwdata  <= wdata;
        @(posedge sys_clk);
        req.penable <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            n++;
            if (n > 20)
                give_up("apb");
        end
        while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        req.psel    <= 1'h0;
        req.penable <= 1'h0;
    endtask

    // Main sequence
    initial
    begin
        logic [3:0] ch;
        logic [1:0] spd;
        logic [9:0] code;
        int         div;
        int         cyc;
        int         b0;
        int         len;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'h1;
        apb(1'h0, sarc_pkg::CTRL_OFS, 32'h0);
        chk_word(rd, {24'h0, sarc_pkg::CTRL_RST}, "ctrl reset");
        apb(1'h0, sarc_pkg::UPPER_OFS, 32'h0);
        chk_word(rd, 32'h0, "upper reset");
        apb(1'h0, 10'h010, 32'h0);
        chk_word(rd, 32'h0, "unmapped data");
        chk_flag(err, 1'h1, "unmapped error");
        apb(1'h1, sarc_pkg::CTRL_OFS, 32'hA6);
        apb(1'h0, sarc_pkg::CTRL_OFS, 32'h0);
        chk_word(rd, 32'hA6, "ctrl fields");
        chk_flag(conv_active, 1'h0, "no start");
        apb(1'h1, sarc_pkg::IRQ_MSK_OFS, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            ch = 4'(3 + 5 * i);
            spd = 2'(i);
            code = {ch, 6'h00} ^ 10'h15B;
            div = (spd == 2'h0) ? int'(sarc_pkg::DIV_SPD0) :
                  (spd == 2'h1) ? int'(sarc_pkg::DIV_SPD1) :
                  (spd == 2'h2) ? int'(sarc_pkg::DIV_SPD2) :
                  int'(sarc_pkg::DIV_SPD3);
            if (i == 5)
                apb(1'h1, sarc_pkg::IRQ_MSK_OFS, 32'h0);
            b0 = busy;
            apb(1'h1, sarc_pkg::CTRL_OFS, {24'h0, ch, 1'h1, spd, 1'h1});
            // Front-end outputs trail the sequencer by one register
            repeat (2) @(posedge sys_clk);
            chk_word({22'h0, dac_trial}, {22'h0, sarc_pkg::MID_SCALE},
                     "first trial");
            chk_word({28'h0, chan}, {28'h0, ch},
                     "channel");
            apb(1'h0, sarc_pkg::CTRL_OFS, 32'h0);
            chk_word(rd, {24'h0, ch, 1'h0, spd, 1'h1},
                     "busy ctrl");
            // A second start in mid-run must not restart the count
            if (i == 2)
                apb(1'h1, sarc_pkg::CTRL_OFS, {24'h0, ch, 1'h0, spd, 1'h1});
            cyc = 0;
            while (conv_active !== 1'h0)
            begin
                @(posedge sys_clk);
                cyc++;
                if (cyc > 1000)
                    give_up("conversion");
            end
            repeat (2) @(posedge sys_clk);
            len = busy - b0;
            chk_flag(len >= sarc_pkg::TOTAL_CLKS * div &&
                     len <= sarc_pkg::TOTAL_CLKS * div + 3, 1'h1,
                     "length");
            chk_flag(irq, i != 5, "irq");
            apb(1'h0, sarc_pkg::CTRL_OFS, 32'h0);
            chk_word(rd, {24'h0, ch, 1'h1, spd, 1'h0},
                     "done ctrl");
            apb(1'h0, sarc_pkg::UPPER_OFS, 32'h0);
            chk_word(rd, {24'h0, code[9:2]}, "upper");
            apb(1'h0, sarc_pkg::LOWER_OFS, 32'h0);
            chk_word(rd, {30'h0, code[1:0]}, "lower");
            apb(1'h0, sarc_pkg::IRQ_ST_OFS, 32'h0);
            chk_word(rd, 32'h1, "status set");
            apb(1'h1, sarc_pkg::IRQ_ST_OFS, 32'h1);
            apb(1'h0, sarc_pkg::IRQ_ST_OFS, 32'h0);
            chk_word(rd, 32'h0, "status clear");
            chk_flag(irq, 1'h0, "irq clear");
        end
        stop_test();
    end

endmodule
`default_nettype wire
